// *** core/interrupt_source_control.sv ***
// Purpose: source control front end of a vectored interrupt controller
// Assumes: Avalon-MM master per the bus contract, CLK never gated
// Notes: one nesting level; end of service returns to idle
`timescale 1ns/100ps
`include "isc_regs.svh"

module interrupt_source_control #(
  parameter int N_PLATFORM = 4,
  parameter logic [31:0] EXT_SRC_MASK = 32'hC000_0001
) (
  input wire logic CLK, // free-running clock
  input wire logic SRST, // sync reset, high
  input wire logic [`ISC_ADDR_W-1:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [3:0] AVS_BYTEENABLE, // byte lanes
  input wire logic [31:0] AVS_WRITEDATA, // write data
  output logic [31:0] AVS_READDATA, // read data
  output logic AVS_WAITREQUEST, // stall, low = done
  input wire logic FAST_SOURCE_PIN, // source 0 pin
  input wire logic [N_PLATFORM-1:0] PLATFORM_IRQ, // platform lines
  input wire logic [31:2] PERIPH_IRQ, // peripheral lines
  input wire logic [31:2] EXTERNAL_REQUEST_PINS, // external pins
  output logic NORMAL_REQUEST_N, // normal request, low
  output logic FAST_REQUEST_N, // fast request, low
  output logic WAKE_REQUEST // idle wake-up, high
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (N_PLATFORM < 1) begin : g_bad_platform
    $error("N_PLATFORM must be at least one");
  end
  if (EXT_SRC_MASK[1]) begin : g_bad_mask
    $error("source one is internal and cannot be a pin");
  end

  // ----------------------------------------------------------------------
  // state and wires
  // ----------------------------------------------------------------------
  localparam int N_SRC = 32;
  // source 0 is always a pin, source 1 never
  localparam logic [31:0] EXT_EFF = {EXT_SRC_MASK[31:2], 2'b01};

  isc_pkg::bus_state_t state_q;
  isc_pkg::bus_req_t req_q;
  isc_pkg::mode_t mode_q [N_SRC];
  logic [31:0] en_q, ff_q, pend, raw, cand, fast_vec;
  logic [31:0] set_vec, clr_vec, auto_clr, wmask, wd_merged;
  logic [63:0] trig_vec;
  logic [95:0] prio_vec;
  logic [31:0] ram_q, rd_d;
  logic [4:0] ram_raddr, sel_idx_q, cur_src_q;
  logic [2:0] sel_prio_q, cur_level_q;
  logic sel_found_q, in_service_q, gmask_q;
  logic [8:0] best;
  logic best_found, normal_cond, fast_cond, acc_rd, acc_wr;
  logic hit_mode, hit_handler, ram_we;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // highest priority wins; walking down means equal levels end on
  // the lowest number
  function automatic logic [8:0] pick_best(input logic [31:0] c,
                                           input logic [95:0] p);
    logic found;
    logic [4:0] idx;
    logic [2:0] bp;
    found = 1'b0;
    idx = 5'h0;
    bp = 3'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (c[i] && (!found || p[3*i +: 3] >= bp)) begin
        found = 1'b1;
        idx = 5'(i);
        bp = p[3*i +: 3];
      end
    end
    return {found, idx, bp};
  endfunction

  // byte enables expanded to a bit mask
  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  // ----------------------------------------------------------------------
  // source wiring
  // ----------------------------------------------------------------------
  // each of 2..31 takes its pin or its peripheral line
  always_comb begin
    raw = '0;
    raw[0] = FAST_SOURCE_PIN;
    raw[1] = |PLATFORM_IRQ;
    for (int i = 2; i < N_SRC; i++) begin
      raw[i] = EXT_EFF[i] ? EXTERNAL_REQUEST_PINS[i] : PERIPH_IRQ[i];
    end
  end

  // flatten the mode table for the stage and the arbiter
  always_comb begin
    trig_vec = '0;
    prio_vec = '0;
    for (int i = 0; i < N_SRC; i++) begin
      trig_vec[2*i +: 2] = mode_q[i].trig;
      prio_vec[3*i +: 3] = mode_q[i].prio;
    end
  end

  source_detect #(
    .N(N_SRC),
    .EXT_MASK(EXT_EFF)
  ) u_detect (
    .clk(CLK),
    .srst(SRST),
    .raw(raw),
    .trig(trig_vec),
    .set_vec(set_vec),
    .clr_vec(clr_vec),
    .pend(pend)
  );

  // ----------------------------------------------------------------------
  // arbitration
  // ----------------------------------------------------------------------
  // fast path: source 0 plus anything forced; masked sources drop out
  always_comb begin
    fast_vec = {ff_q[31:1], 1'b1};
    fast_cond = |(pend & en_q & fast_vec);
    cand = pend & en_q & ~fast_vec;
    best = pick_best(cand, prio_vec);
    best_found = best[8];
    // while in service only a strictly higher level re-raises
    normal_cond = best_found && (!in_service_q || best[2:0] > cur_level_q);
  end

  // ----------------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------------
  // idle takes the request, access does the work, done answers
  always_ff @(posedge CLK) begin
    if (SRST) begin
      state_q <= isc_pkg::BUS_IDLE;
    end else begin
      case (state_q)
        isc_pkg::BUS_IDLE: begin
          if (AVS_READ || AVS_WRITE) begin
            state_q <= isc_pkg::BUS_ACCESS;
          end
        end
        isc_pkg::BUS_ACCESS: state_q <= isc_pkg::BUS_DONE;
        isc_pkg::BUS_DONE: state_q <= isc_pkg::BUS_IDLE;
        default: state_q <= isc_pkg::BUS_IDLE;
      endcase
    end
  end

  // capture the request and the arbiter's choice at the same edge,
  // so the vector read returns the source it clears
  always_ff @(posedge CLK) begin
    if (SRST) begin
      req_q <= '0;
      sel_found_q <= 1'b0;
      sel_idx_q <= 5'h0;
      sel_prio_q <= 3'h0;
    end else if (state_q == isc_pkg::BUS_IDLE) begin
      req_q <= '{addr: AVS_ADDRESS, rd: AVS_READ, wr: AVS_WRITE,
                 be: AVS_BYTEENABLE, wdata: AVS_WRITEDATA};
      sel_found_q <= best_found;
      sel_idx_q <= best[7:3];
      sel_prio_q <= best[2:0];
    end
  end

  // read index: chosen source, source 0, or the addressed word
  always_comb begin
    if (AVS_ADDRESS == `ISC_VECTOR) begin
      ram_raddr = best[7:3];
    end else if (AVS_ADDRESS == `ISC_FAST_VECTOR) begin
      ram_raddr = 5'h0;
    end else begin
      ram_raddr = AVS_ADDRESS[6:2];
    end
  end

  // decode of the captured request, live only in the access cycle
  always_comb begin
    acc_rd = (state_q == isc_pkg::BUS_ACCESS) && req_q.rd;
    acc_wr = (state_q == isc_pkg::BUS_ACCESS) && req_q.wr;
    hit_mode = req_q.addr[8:7] == 2'b00;
    hit_handler = req_q.addr[8:7] == 2'b01;
    wmask = lane_mask(req_q.be);
    wd_merged = (ram_q & ~wmask) | (req_q.wdata & wmask);
    ram_we = acc_wr && hit_handler;
  end

  vector_ram #(
    .DEPTH(N_SRC),
    .WIDTH(32)
  ) u_handlers (
    .clk(CLK),
    .we(ram_we),
    .waddr(req_q.addr[6:2]),
    .wdata(wd_merged),
    .raddr(ram_raddr),
    .rdata_q(ram_q)
  );

  // ----------------------------------------------------------------------
  // commands
  // ----------------------------------------------------------------------
  // the current source loses only its own edge flag on a vector read
  always_comb begin
    auto_clr = '0;
    if (acc_rd && req_q.addr == `ISC_VECTOR && sel_found_q &&
        !fast_vec[sel_idx_q]) begin
      auto_clr[sel_idx_q] = 1'b1;
    end
    if (acc_rd && req_q.addr == `ISC_FAST_VECTOR) begin
      auto_clr[0] = 1'b1;
    end
    set_vec = (acc_wr && req_q.addr == `ISC_SET) ?
              (req_q.wdata & wmask) : '0;
    clr_vec = auto_clr | ((acc_wr && req_q.addr == `ISC_CLEAR) ?
              (req_q.wdata & wmask) : '0);
  end

  // mask: one write enables, one write disables; all off at reset
  always_ff @(posedge CLK) begin
    if (SRST) begin
      en_q <= '0;
    end else if (acc_wr && req_q.addr == `ISC_ENABLE) begin
      en_q <= en_q | (req_q.wdata & wmask);
    end else if (acc_wr && req_q.addr == `ISC_DISABLE) begin
      en_q <= en_q & ~(req_q.wdata & wmask);
    end
  end

  // fast forcing word, bit 0 stored but read as zero; general mask a single bit, lane 0 only
  always_ff @(posedge CLK) begin
    if (SRST) begin
      ff_q <= '0;
      gmask_q <= 1'b0;
    end else if (acc_wr && req_q.addr == `ISC_FAST_FORCE) begin
      ff_q <= (ff_q & ~wmask) | (req_q.wdata & wmask);
    end else if (acc_wr && req_q.addr == `ISC_GEN_MASK && req_q.be[0]) begin
      gmask_q <= req_q.wdata[0];
    end
  end

  // mode table, both fields written only when byte lane 0 is enabled
  always_ff @(posedge CLK) begin
    if (SRST) begin
      for (int i = 0; i < N_SRC; i++) begin
        mode_q[i] <= '0;
      end
    end else if (acc_wr && hit_mode) begin
      if (req_q.be[0]) begin
        mode_q[req_q.addr[6:2]].prio <=
          req_q.wdata[`ISC_PRIO_MSB:`ISC_PRIO_LSB];
        mode_q[req_q.addr[6:2]].trig <=
          req_q.wdata[`ISC_TRIG_MSB:`ISC_TRIG_LSB];
      end
    end
  end

  // ----------------------------------------------------------------------
  // service state
  // ----------------------------------------------------------------------
  // a vector read enters service, end of service leaves it
  always_ff @(posedge CLK) begin
    if (SRST) begin
      in_service_q <= 1'b0;
      cur_src_q <= 5'h0;
      cur_level_q <= 3'h0;
    end else if (acc_rd && req_q.addr == `ISC_VECTOR && sel_found_q) begin
      in_service_q <= 1'b1;
      cur_src_q <= sel_idx_q;
      cur_level_q <= sel_prio_q;
    end else if (acc_wr && req_q.addr == `ISC_END_SERVICE) begin
      in_service_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  always_comb begin
    rd_d = `ISC_RESET_WORD;
    if (hit_mode) begin
      rd_d[`ISC_PRIO_MSB:`ISC_PRIO_LSB] = mode_q[req_q.addr[6:2]].prio;
      rd_d[`ISC_TRIG_MSB:`ISC_TRIG_LSB] = mode_q[req_q.addr[6:2]].trig;
    end else if (hit_handler) begin
      rd_d = ram_q;
    end else begin
      case (req_q.addr)
        `ISC_VECTOR: rd_d = sel_found_q ? ram_q : `ISC_SPURIOUS_VALUE;
        `ISC_FAST_VECTOR: rd_d = ram_q;
        `ISC_CURRENT: rd_d[4:0] = cur_src_q;
        `ISC_PENDING: rd_d = pend;
        `ISC_MASK: rd_d = en_q;
        `ISC_CORE_LINES: begin
          rd_d[`ISC_CORE_NORMAL_BIT] = ~NORMAL_REQUEST_N;
          rd_d[`ISC_CORE_FAST_BIT] = ~FAST_REQUEST_N;
        end
        `ISC_FAST_FORCE: rd_d = {ff_q[31:1], 1'b0};
        `ISC_GEN_MASK: rd_d[0] = gmask_q;
        default: rd_d = `ISC_RESET_WORD; // unmapped reads zero
      endcase
    end
  end

  // answer one cycle after the access; waitrequest idles high
  always_ff @(posedge CLK) begin
    if (SRST) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA <= '0;
    end else begin
      AVS_WAITREQUEST <= state_q != isc_pkg::BUS_ACCESS;
      if (acc_rd) begin
        AVS_READDATA <= rd_d;
      end
    end
  end

  // ----------------------------------------------------------------------
  // core lines
  // ----------------------------------------------------------------------
  // registered outputs; the general mask keeps the lines quiet but
  // still wakes the core, so software can wait on an event
  always_ff @(posedge CLK) begin
    if (SRST) begin
      NORMAL_REQUEST_N <= 1'b1;
      FAST_REQUEST_N <= 1'b1;
      WAKE_REQUEST <= 1'b0;
    end else begin
      NORMAL_REQUEST_N <= ~(normal_cond & ~gmask_q);
      FAST_REQUEST_N <= ~(fast_cond & ~gmask_q);
      WAKE_REQUEST <= normal_cond | fast_cond;
    end
  end

endmodule // interrupt_source_control

// *** core/isc_pkg.sv ***
// Purpose: shared types of the interrupt source control
// Assumes: isc_regs.svh on the include path
// Notes: the address width comes from the header, the field widths are literal
`include "isc_regs.svh"

package isc_pkg;

  // per-source programming
  typedef struct packed {
    logic [1:0] trig;
    logic [2:0] prio;
  } mode_t;

  // one captured bus request
  typedef struct packed {
    logic [`ISC_ADDR_W-1:0] addr;
    logic rd;
    logic wr;
    logic [3:0] be;
    logic [31:0] wdata;
  } bus_req_t;

  typedef enum logic [1:0] {BUS_IDLE, BUS_ACCESS, BUS_DONE} bus_state_t;

endpackage

// *** core/isc_regs.svh ***
// Purpose: offsets, field positions, reset values of the source control
// Assumes: 32-bit Avalon-MM slave, byte addresses, one word per register
// Notes: included by the package and by the top module
//
// Notes on behaviour
// - thirty-two maskable sources, eight priority levels
// - drive fast and normal request outputs
// - internal sources level or edge, no polarity
// - pins: rising, falling, high or low
// - fast forcing routes any source to fast
// - clock never gated, always running
// - either request also wakes idle core
// - general mask wakes without asserting requests
// - source zero is the fast pin
// - source one ORs platform interrupt lines
// - sources 2-31 peripheral or external pins
// - mode register holds trigger select field
// - enable and disable commands, mask readable
// - disabled source never influences servicing
// - set and clear act on edge sources only
// - vector read clears current edge only
// - no auto clear for fast forced sources
// - fast vector read clears source zero
// - pending readback shows activity, masked or not
// - current number readback gives serviced source
// - core line image shows both request lines
// - pin routing adds no latency
// - priority 0..7, seven highest
// - equal priority: lowest number wins
// - vector read deasserts normal, returns handler
`ifndef ISC_REGS_SVH
`define ISC_REGS_SVH

// ----------------------------------------------------------------------
// address map
// ----------------------------------------------------------------------
`define ISC_ADDR_W 9
`define ISC_MODE_BASE 9'h000
`define ISC_HANDLER_BASE 9'h080
`define ISC_VECTOR 9'h100
`define ISC_FAST_VECTOR 9'h104
`define ISC_CURRENT 9'h108
`define ISC_PENDING 9'h10C
`define ISC_MASK 9'h110
`define ISC_CORE_LINES 9'h114
`define ISC_ENABLE 9'h120
`define ISC_DISABLE 9'h124
`define ISC_CLEAR 9'h128
`define ISC_SET 9'h12C
`define ISC_END_SERVICE 9'h130
`define ISC_FAST_FORCE 9'h134
`define ISC_GEN_MASK 9'h138

// ----------------------------------------------------------------------
// fields and encodings
// ----------------------------------------------------------------------
`define ISC_PRIO_LSB 0
`define ISC_PRIO_MSB 2
`define ISC_TRIG_LSB 5
`define ISC_TRIG_MSB 6
`define ISC_TRIG_HIGH 2'h0
`define ISC_TRIG_RISE 2'h1
`define ISC_TRIG_LOW 2'h2
`define ISC_TRIG_FALL 2'h3
`define ISC_CORE_NORMAL_BIT 0
`define ISC_CORE_FAST_BIT 1
`define ISC_SPURIOUS_VALUE 32'h0000_0000
`define ISC_RESET_WORD 32'h0000_0000

`endif

// *** core/source_detect.sv ***
// Purpose: per-source input stage, edge memory and pending state
// Assumes: external lines asynchronous, internal lines on clk
// Notes: trig packs two bits per source, edge flag at bit 0
`timescale 1ns/100ps

module source_detect #(
  parameter int N = 32,
  parameter logic [31:0] EXT_MASK = 32'h0000_0001
) (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic [N-1:0] raw, // source lines
  input wire logic [2*N-1:0] trig, // trigger selects
  input wire logic [N-1:0] set_vec, // software set
  input wire logic [N-1:0] clr_vec, // software or auto clear
  output logic [N-1:0] pend // pending state
);

  logic [N-1:0] s1_q, s2_q, s3_q, lvl_q, prev_q, flag_q;
  logic [N-1:0] lvl, act, prev_act, hit, edge_mode;

  // the pin mask is one word wide, so more sources cannot be served
  if (N < 1 || N > 32) begin : g_bad_n
    $error("N must lie between 1 and 32");
  end

  // three-stage synchroniser, same path for direct or muxed pins
  always_ff @(posedge clk) begin
    if (srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // a change counts once stages two and three agree
  always_ff @(posedge clk) begin
    if (srst) begin
      lvl_q <= '0;
    end else begin
      for (int i = 0; i < N; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          lvl_q[i] <= s3_q[i];
        end
      end
    end
  end

  // internal lines are active high; only pins honour polarity
  always_comb begin
    for (int i = 0; i < N; i++) begin
      edge_mode[i] = trig[2*i];
      lvl[i] = EXT_MASK[i] ? lvl_q[i] : raw[i];
      act[i] = lvl[i] ^ (EXT_MASK[i] & trig[2*i+1]);
      prev_act[i] = prev_q[i] ^ (EXT_MASK[i] & trig[2*i+1]);
      hit[i] = edge_mode[i] & act[i] & ~prev_act[i];
      pend[i] = edge_mode[i] ? flag_q[i] : act[i];
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      prev_q <= '0;
    end else begin
      prev_q <= lvl;
    end
  end

  // edge memory; a new edge or set beats a clear in the same cycle
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= '0;
    end else begin
      flag_q <= edge_mode & ((flag_q & ~clr_vec) | hit | set_vec);
    end
  end

endmodule // source_detect

// *** core/vector_ram.sv ***
// Purpose: handler address store, one word per source
// Assumes: single clock, write and read ports independent
// Notes: read data registered, one cycle after the address
`timescale 1ns/100ps

module vector_ram #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 32
) (
  input wire logic clk, // clock
  input wire logic we, // write strobe
  input wire logic [$clog2(DEPTH)-1:0] waddr, // write index
  input wire logic [WIDTH-1:0] wdata, // write word
  input wire logic [$clog2(DEPTH)-1:0] raddr, // read index
  output logic [WIDTH-1:0] rdata_q // registered read word
);

  logic [WIDTH-1:0] mem [DEPTH];

  // a one-word store would leave the index without any bits
  if (DEPTH < 2 || WIDTH < 1) begin : g_bad_size
    $error("DEPTH must be at least two and WIDTH at least one");
  end

  // plain array, no reset: contents are software's to load
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // registered read keeps the bus answer off the array's output path
  always_ff @(posedge clk) begin
    rdata_q <= mem[raddr];
  end

endmodule // vector_ram

// *** test/core_model.sv ***
// Purpose: processor core idle state as seen from the request lines
// Assumes: sleep pulsed by the bench
// Notes: only idle entry and wake-up are modelled
`timescale 1ns/100ps

module core_model (
  input wire logic clk, // clock
  input wire logic srst, // sync reset
  input wire logic sleep, // enter idle
  input wire logic wake, // wake-up request
  output logic idle_q // core idle
);
  // wake wins over sleep so an event is never lost
  always_ff @(posedge clk) begin
    if (srst)
      idle_q <= 1'b0;
    else if (wake)
      idle_q <= 1'b0;
    else if (sleep)
      idle_q <= 1'b1;
  end
endmodule // core_model

// *** test/interrupt_source_control_bench.sv ***
// Purpose: register level tests of the source control
// Assumes: two-edge bus answer, pins synced in four edges
// Notes: settle waits eight cycles, longer than any sync path
`timescale 1ns/100ps
`include "isc_regs.svh"

module interrupt_source_control_bench;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [`ISC_ADDR_W-1:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic sleep = 1'b0;
  logic fast_pin = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] plat = '0;
  logic [31:2] periph = '0;
  logic [31:2] pins = '0;
  logic [31:0] rdata, v;
  logic waitreq, normal_n, fast_n, wake, idle;
  int mismatches = 0;
  int cmp_count = 0;

  interrupt_source_control dut (.CLK(clk), .SRST(srst), .AVS_ADDRESS(addr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_BYTEENABLE(4'hF),
    .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .FAST_SOURCE_PIN(fast_pin), .PLATFORM_IRQ(plat), .PERIPH_IRQ(periph),
    .EXTERNAL_REQUEST_PINS(pins), .NORMAL_REQUEST_N(normal_n),
    .FAST_REQUEST_N(fast_n), .WAKE_REQUEST(wake));
  core_model core (.clk(clk), .srst(srst), .sleep(sleep), .wake(wake),
    .idle_q(idle));

  initial begin
    forever #50 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus transfer; request held until wait request is seen low
  task automatic xfer(input logic w, input logic [8:0] a,
                      input logic [31:0] d);
    int n;
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= !w;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    if (n == 20) mismatches++;
    v = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask

  task automatic rchk(input logic [8:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0000_0000);
    check(v, e);
  endtask

  task automatic settle;
    repeat (8) @(negedge clk);
  endtask

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge clk);
    mismatches++;
    conclude();
  end

  initial begin
    repeat (20) @(posedge clk);
    srst <= 1'b0;
    // reset state and command register reads
    check({30'h0, fast_n, normal_n}, 32'h0000_0003);
    rchk(`ISC_MASK, 32'h0000_0000);
    rchk(9'h1FC, 32'h0000_0000);
    rchk(`ISC_ENABLE, 32'h0000_0000);
    xfer(1'b1, `ISC_ENABLE, 32'h0000_00F0);
    xfer(1'b1, `ISC_DISABLE, 32'h0000_0060);
    rchk(`ISC_MASK, 32'h0000_0090);
    // 4 rising prio 6, 5 and 7 rising prio 3, 6 level
    xfer(1'b1, `ISC_MODE_BASE + 9'h010, 32'h0000_0026);
    xfer(1'b1, `ISC_MODE_BASE + 9'h014, 32'h0000_0023);
    xfer(1'b1, `ISC_MODE_BASE + 9'h01C, 32'h0000_0023);
    rchk(`ISC_MODE_BASE + 9'h010, 32'h0000_0026);
    for (int i = 4; i < 8; i++) begin
      xfer(1'b1, `ISC_HANDLER_BASE + 9'(4 * i), 32'h1000_0000 + i);
    end
    xfer(1'b1, `ISC_SET, 32'h0000_00F0);
    rchk(`ISC_PENDING, 32'h0000_00B0);
    settle();
    check({31'h0, normal_n}, 32'h0000_0000);
    rchk(`ISC_CORE_LINES, 32'h0000_0001);
    rchk(`ISC_VECTOR, 32'h1000_0004);
    rchk(`ISC_CURRENT, 32'h0000_0004);
    rchk(`ISC_PENDING, 32'h0000_00A0);
    settle();
    check({31'h0, normal_n}, 32'h0000_0001);
    // masked source 5 must not win over 7
    xfer(1'b1, `ISC_END_SERVICE, 32'h0000_0000);
    rchk(`ISC_VECTOR, 32'h1000_0007);
    xfer(1'b1, `ISC_END_SERVICE, 32'h0000_0000);
    xfer(1'b1, `ISC_SET, 32'h0000_0080);
    xfer(1'b1, `ISC_ENABLE, 32'h0000_0020);
    rchk(`ISC_VECTOR, 32'h1000_0005);
    // forced source keeps its flag over a vector read
    xfer(1'b1, `ISC_FAST_FORCE, 32'h0000_0080);
    settle();
    check({31'h0, fast_n}, 32'h0000_0000);
    xfer(1'b0, `ISC_VECTOR, 32'h0000_0000);
    rchk(`ISC_PENDING, 32'h0000_0080);
    xfer(1'b1, `ISC_CLEAR, 32'h0000_0080);
    xfer(1'b1, `ISC_FAST_FORCE, 32'h0000_0000);
    settle();
    check({31'h0, fast_n}, 32'h0000_0001);
    // source 0 on the fast pin, rising edge
    xfer(1'b1, `ISC_MODE_BASE, 32'h0000_0020);
    xfer(1'b1, `ISC_HANDLER_BASE, 32'h2000_0000);
    xfer(1'b1, `ISC_ENABLE, 32'h0000_0001);
    @(posedge clk) fast_pin <= 1'b1;
    settle();
    check({31'h0, fast_n}, 32'h0000_0000);
    rchk(`ISC_FAST_VECTOR, 32'h2000_0000);
    rchk(`ISC_PENDING, 32'h0000_0000);
    fast_pin <= 1'b0;
    // general mask: core wakes, request line stays off
    xfer(1'b1, `ISC_END_SERVICE, 32'h0000_0000);
    xfer(1'b1, `ISC_ENABLE, 32'h0000_0002);
    xfer(1'b1, `ISC_GEN_MASK, 32'h0000_0001);
    @(posedge clk) sleep <= 1'b1;
    @(posedge clk) sleep <= 1'b0;
    settle();
    check({31'h0, idle}, 32'h0000_0001);
    @(posedge clk) plat <= 4'h4;
    settle();
    check({30'h0, idle, normal_n}, 32'h0000_0001);
    rchk(`ISC_PENDING, 32'h0000_0002);
    xfer(1'b1, `ISC_GEN_MASK, 32'h0000_0000);
    settle();
    check({31'h0, normal_n}, 32'h0000_0000);
    @(posedge clk) plat <= 4'h0;
    settle();
    check({31'h0, normal_n}, 32'h0000_0001);
    // pin 31: high and low level against both pin levels
    for (int k = 0; k < 4; k++) begin
      xfer(1'b1, `ISC_MODE_BASE + 9'h07C, {25'h0, k[1], 1'b0, 5'h0});
      @(posedge clk) pins[31] <= k[0];
      settle();
      rchk(`ISC_PENDING, {k[0] ^ k[1], 31'h0});
    end
    // pin 30: rising then falling edge
    for (int k = 1; k < 4; k += 2) begin
      xfer(1'b1, `ISC_MODE_BASE + 9'h078, {25'h0, k[1:0], 5'h0});
      @(posedge clk) pins[30] <= ~pins[30];
      settle();
      rchk(`ISC_PENDING, 32'h4000_0000);
      xfer(1'b1, `ISC_CLEAR, 32'h4000_0000);
    end
    // short internal pulse stays latched
    xfer(1'b1, `ISC_MODE_BASE + 9'h024, 32'h0000_0020);
    @(posedge clk) periph[9] <= 1'b1;
    @(posedge clk) periph[9] <= 1'b0;
    settle();
    rchk(`ISC_PENDING, 32'h0000_0200);
    conclude();
  end
endmodule // interrupt_source_control_bench

// *** test/isc_asserts.sv ***
// Purpose: bus timing and request line checks of the source control
// Assumes: sees only the top module ports
// Notes: bound to the design at the foot of this file
`timescale 1ns/100ps
`include "isc_regs.svh"

module isc_checker (
  input wire logic CLK, // clock
  input wire logic SRST, // sync reset
  input wire logic [`ISC_ADDR_W-1:0] AVS_ADDRESS, // byte address
  input wire logic AVS_READ, // read request
  input wire logic AVS_WRITE, // write request
  input wire logic [31:0] AVS_READDATA, // read data
  input wire logic AVS_WAITREQUEST, // stall
  input wire logic NORMAL_REQUEST_N, // normal request
  input wire logic FAST_REQUEST_N, // fast request
  input wire logic WAKE_REQUEST // wake-up
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (SRST);

  // bus answers a fresh request after exactly two edges
  a_answer_time: assert property (
    $rose(AVS_READ) || $rose(AVS_WRITE) |-> ##2 !AVS_WAITREQUEST)
    else $error("bus answer not on time");
  a_wait_pulse: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST [*2])
    else $error("wait request low too long");
  a_wait_cause: assert property (
    !AVS_WAITREQUEST |-> AVS_READ || AVS_WRITE)
    else $error("answer without request");
  // read data only moves on the completing edge
  a_rdata_hold: assert property (
    AVS_WAITREQUEST |-> $stable(AVS_READDATA))
    else $error("read data moved while idle");
  a_cmd_read_zero: assert property (
    AVS_READ && !AVS_WAITREQUEST && AVS_ADDRESS == `ISC_ENABLE
    |-> AVS_READDATA == 32'h0000_0000)
    else $error("command register read not zero");
  // reset itself must quiet both lines, so no disable here
  a_reset_quiet: assert property (disable iff (1'b0)
    SRST |=> NORMAL_REQUEST_N && FAST_REQUEST_N && !WAKE_REQUEST)
    else $error("request active after reset");
  a_after_reset: assert property (
    $fell(SRST) |-> (NORMAL_REQUEST_N && FAST_REQUEST_N) [*3])
    else $error("request soon after reset");
  a_wake_follows: assert property (
    !NORMAL_REQUEST_N || !FAST_REQUEST_N |-> WAKE_REQUEST)
    else $error("request without wake");

  c_fast: cover property (!FAST_REQUEST_N);
  c_masked_wake: cover property (WAKE_REQUEST && NORMAL_REQUEST_N);
  c_vector: cover property (AVS_READ && !AVS_WAITREQUEST
    && AVS_ADDRESS == `ISC_VECTOR);
endmodule // isc_checker

bind interrupt_source_control isc_checker u_chk (.CLK(CLK), .SRST(SRST),
  .AVS_ADDRESS(AVS_ADDRESS), .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE),
  .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST),
  .NORMAL_REQUEST_N(NORMAL_REQUEST_N), .FAST_REQUEST_N(FAST_REQUEST_N),
  .WAKE_REQUEST(WAKE_REQUEST));
